//--- remappable_pin_select_map.sv
// remappable pin select map: AHB-Lite register file, input routing to
// PWM fault 4..8 and two sync inputs, output function numbers per pin.
// assumes a single AHB-Lite master, pins synchronous to clk.
`timescale 1ns/1ns
`default_nettype none
module remappable_pin_select_map
  import pin_select_pkg::*;
#(
  parameter int unsigned PINS       = PIN_COUNT,
  parameter bit          SMALL_PART = 1'b0
)(
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  // AHB-Lite slave
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic                   hready,
  input  wire logic [31:0]            hwdata,
  output var  logic [31:0]            hrdata,
  output var  logic                   hreadyout,
  output var  logic                   hresp,
  // remappable pins
  input  wire logic [PINS-1:0]        remappable_pin,
  // routed PWM inputs
  output var  logic                   pwm_fault_input_4,
  output var  logic                   pwm_fault_input_5,
  output var  logic                   pwm_fault_input_6,
  output var  logic                   pwm_fault_input_7,
  output var  logic                   pwm_fault_input_8,
  output var  logic                   pwm_sync_input_a,
  output var  logic                   pwm_sync_input_b,
  // output function numbers, pin n in bits 6n+5..6n
  output var  logic [OUT_PINS*6-1:0]  pin_function_choice,
  // high where the pin stays under port control
  output var  logic [OUT_PINS-1:0]    pin_port_owned
);

  // ==========================================================
  // address phase capture
  reg_access_t acc;
  logic        acc_valid;

  wire take = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      acc_valid <= 1'b0;
      acc       <= '0;
    end
    else if (hready)
    begin
      acc_valid <= take;
      acc       <= '{write: hwrite, addr: haddr[5:0], wdata: 16'h0000};
    end
  end

  // ==========================================================
  // decode
  wire wr_phase = acc_valid && acc.write;
  wire rd_take  = take && !hwrite;
  wire [5:0] rd_addr = haddr[5:0];

  localparam int unsigned OUT_LIVE = SMALL_PART ? SMALL_OUT_REGS : OUT_REGS;

  function automatic logic hit(input logic [5:0] a, input logic [5:0] base);
    hit = (a == base);
  endfunction : hit

  // ==========================================================
  // input select registers
  logic [15:0] fault_select_5_4;
  logic [15:0] fault_select_7_6;
  logic [15:0] sync1_fault8_select;
  logic [15:0] sync2_select;

  // reset to ground, fault field layout
  select_pair_reg #(.IMPL_MASK(IMPL_MASK_PAIR), .RESET_CODE(IN_SEL_RESET)) u_flt54 (
    .clk     (clk),
    .sys_rst (sys_rst),
    .wr_en   (wr_phase && hit(acc.addr, ADDR_FAULT_5_4)),
    .wr_data (hwdata[15:0]),
    .value   (fault_select_5_4)
  );

  select_pair_reg #(.IMPL_MASK(IMPL_MASK_PAIR), .RESET_CODE(IN_SEL_RESET)) u_flt76 (
    .clk     (clk),
    .sys_rst (sys_rst),
    .wr_en   (wr_phase && hit(acc.addr, ADDR_FAULT_7_6)),
    .wr_data (hwdata[15:0]),
    .value   (fault_select_7_6)
  );

  // sync a in the high field
  select_pair_reg #(.IMPL_MASK(IMPL_MASK_PAIR), .RESET_CODE(IN_SEL_RESET)) u_sy1f8 (
    .clk     (clk),
    .sys_rst (sys_rst),
    .wr_en   (wr_phase && hit(acc.addr, ADDR_SYNC1_F8)),
    .wr_data (hwdata[15:0]),
    .value   (sync1_fault8_select)
  );

  // sync b low field, upper byte absent
  select_pair_reg #(.IMPL_MASK(IMPL_MASK_LOW), .RESET_CODE(IN_SEL_RESET)) u_sy2 (
    .clk     (clk),
    .sys_rst (sys_rst),
    .wr_en   (wr_phase && hit(acc.addr, ADDR_SYNC2)),
    .wr_data (hwdata[15:0]),
    .value   (sync2_select)
  );

  wire [5:0] fault4_pin_choice   = fault_select_5_4[5:0];
  wire [5:0] fault5_pin_choice   = fault_select_5_4[13:8];
  wire [5:0] fault6_pin_choice   = fault_select_7_6[5:0];
  wire [5:0] fault7_pin_choice   = fault_select_7_6[13:8];
  wire [5:0] fault8_pin_choice   = sync1_fault8_select[5:0];
  wire [5:0] sync_in_a_pin_choice = sync1_fault8_select[13:8];
  wire [5:0] sync_in_b_pin_choice = sync2_select[5:0];

  // ==========================================================
  // output select registers
  logic [15:0] out_select [OUT_REGS];

  // function numbers per pin pair, small part lacks upper ones
  genvar g;
  generate
    for (g = 0; g < OUT_REGS; g++)
    begin : g_out
      if (g < OUT_LIVE)
      begin : g_live
        select_pair_reg #(.IMPL_MASK(IMPL_MASK_PAIR), .RESET_CODE(OUT_SEL_RESET)) u_or (
          .clk     (clk),
          .sys_rst (sys_rst),
          .wr_en   (wr_phase && hit(acc.addr, ADDR_OUT_BASE + 6'(4*g))),
          .wr_data (hwdata[15:0]),
          .value   (out_select[g])
        );
      end
      else
      begin : g_absent
        assign out_select[g] = 16'h0000;
      end
    end
  endgenerate

  // ==========================================================
  // input routing: ground, high pins, code equals index
  logic [IN_COUNT-1:0] routed;
  wire  [IN_COUNT*6-1:0] in_choice = {sync_in_b_pin_choice, sync_in_a_pin_choice,
                                      fault8_pin_choice, fault7_pin_choice,
                                      fault6_pin_choice, fault5_pin_choice,
                                      fault4_pin_choice};
  generate
    for (g = 0; g < IN_COUNT; g++)
    begin : g_in
      pin_input_route #(.PINS(PINS)) u_route (
        .clk     (clk),
        .sys_rst (sys_rst),
        .choice  (in_choice[g*6 +: 6]),
        .pins    (remappable_pin),
        .routed  (routed[g])
      );
    end
  endgenerate

  assign pwm_fault_input_4 = routed[0];
  assign pwm_fault_input_5 = routed[1];
  assign pwm_fault_input_6 = routed[2];
  assign pwm_fault_input_7 = routed[3];
  assign pwm_fault_input_8 = routed[4];
  assign pwm_sync_input_a  = routed[5];
  assign pwm_sync_input_b  = routed[6];

  // ==========================================================
  // output function view: zero keeps port control
  logic [OUT_PINS*6-1:0] next_function;
  logic [OUT_PINS-1:0]   next_owned;
  always_comb
  begin
    next_function = '0;
    next_owned    = '0;
    for (int i = 0; i < OUT_PINS; i++)
    begin
      next_function[i*6 +: 6] = out_select[i/2][(i%2)*8 +: 6];
      next_owned[i] = (out_select[i/2][(i%2)*8 +: 6] == FUNC_PORT_CTRL);
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pin_function_choice <= '0;
      pin_port_owned      <= '1;
    end
    else
    begin
      pin_function_choice <= next_function;
      pin_port_owned      <= next_owned;
    end
  end

  // ==========================================================
  // read mux: unimplemented bits come back as zero
  logic [15:0] rd_word;
  always_comb
  begin
    rd_word = 16'h0000;
    case (rd_addr)
      ADDR_FAULT_5_4: rd_word = fault_select_5_4;
      ADDR_FAULT_7_6: rd_word = fault_select_7_6;
      ADDR_SYNC1_F8:  rd_word = sync1_fault8_select;
      ADDR_SYNC2:     rd_word = sync2_select;
      default:
      begin
        for (int j = 0; j < OUT_REGS; j++)
          if (rd_addr == ADDR_OUT_BASE + 6'(4*j))
            rd_word = out_select[j];
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      hrdata <= 32'h0000_0000;
    else if (rd_take)
      hrdata <= {16'h0000, rd_word & IMPL_MASK_PAIR};
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // ==========================================================
  // checks
  // ground code gives a low input
  property p_ground;
    @(posedge clk) disable iff (sys_rst)
    (fault4_pin_choice == SEL_GROUND) |=> !pwm_fault_input_4;
  endproperty
  a_ground: assert property (p_ground) else $error("grounded fault4 not low");

  property p_high_pin;
    @(posedge clk) disable iff (sys_rst)
    (fault5_pin_choice == 6'h23) |=> (pwm_fault_input_5 == $past(remappable_pin[35]));
  endproperty
  a_high_pin: assert property (p_high_pin) else $error("code 35 misrouted");

  property p_pin_zero;
    @(posedge clk) disable iff (sys_rst)
    (sync_in_a_pin_choice == 6'h00) |=> (pwm_sync_input_a == $past(remappable_pin[0]));
  endproperty
  a_pin_zero: assert property (p_pin_zero) else $error("code 0 misrouted");

  property p_reset_vals;
    @(posedge clk) $fell(sys_rst) |-> (sync2_select == 16'h003f) && (out_select[0] == 16'h0000);
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset value");

  property p_reserved;
    @(posedge clk) disable iff (sys_rst)
    $rose(acc_valid) ##0 !acc.write |-> (hrdata[15:14] == 2'h0) && (hrdata[7:6] == 2'h0);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits set");

  property p_sync2_upper;
    @(posedge clk) disable iff (sys_rst) sync2_select[15:8] == 8'h00;
  endproperty
  a_sync2_upper: assert property (p_sync2_upper) else $error("sync b upper byte set");

  // function output tracks register within two cycles
  sequence s_out_write;
    wr_phase && hit(acc.addr, ADDR_OUT_BASE);
  endsequence
  property p_func_track;
    @(posedge clk) disable iff (sys_rst)
    s_out_write |=> ##1 (pin_function_choice[11:6] == out_select[0][13:8]);
  endproperty
  a_func_track: assert property (p_func_track) else $error("pin1 function lag");

  property p_port_owned;
    @(posedge clk) disable iff (sys_rst)
    (out_select[0][5:0] == 6'h00) |=> pin_port_owned[0];
  endproperty
  a_port_owned: assert property (p_port_owned) else $error("pin0 not port owned");

endmodule : remappable_pin_select_map
`default_nettype wire

//--- pin_select_pkg.sv
// package for the remappable pin select map
// assumes one 20 MHz clock domain and a single AHB-Lite master
package pin_select_pkg;

  // ==========================================================
  // field layout
  localparam int unsigned SEL_W      = 6;
  localparam int unsigned HI_LSB     = 8;
  localparam int unsigned LO_LSB     = 0;
  localparam int unsigned PIN_COUNT  = 36;
  localparam int unsigned OUT_PINS   = 14;
  localparam int unsigned IN_COUNT   = 7;

  // ==========================================================
  // codes and reset values
  localparam logic [5:0]  SEL_GROUND      = 6'h3f;
  localparam logic [5:0]  IN_SEL_RESET    = 6'h3f;
  localparam logic [5:0]  OUT_SEL_RESET   = 6'h00;
  localparam logic [5:0]  FUNC_PORT_CTRL  = 6'h00;
  localparam logic [15:0] IMPL_MASK_PAIR  = 16'h3f3f;
  localparam logic [15:0] IMPL_MASK_LOW   = 16'h003f;

  // ==========================================================
  // register byte addresses
  localparam logic [5:0] ADDR_FAULT_5_4   = 6'h00;
  localparam logic [5:0] ADDR_FAULT_7_6   = 6'h04;
  localparam logic [5:0] ADDR_SYNC1_F8    = 6'h08;
  localparam logic [5:0] ADDR_SYNC2       = 6'h0c;
  localparam logic [5:0] ADDR_OUT_BASE    = 6'h10;
  localparam int unsigned OUT_REGS        = 7;
  localparam int unsigned SMALL_OUT_REGS  = 4;

  // ==========================================================
  // bus carriers
  typedef struct packed {
    logic        sel;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] haddr;
  } ahb_req_t;

  typedef struct packed {
    logic        write;
    logic [5:0]  addr;
    logic [15:0] wdata;
  } reg_access_t;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;

endpackage : pin_select_pkg

//--- select_pair_reg.sv
// one selection register: up to two 6-bit fields as IMPL_MASK allows, unimplemented bits zero
// assumes writes come from the bus slave one cycle after the address phase
`timescale 1ns/1ns
`default_nettype none
module select_pair_reg
  import pin_select_pkg::*;
#(
  parameter logic [15:0] IMPL_MASK  = IMPL_MASK_PAIR,
  parameter logic [5:0]  RESET_CODE = IN_SEL_RESET
)(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // write port
  input  wire logic        wr_en,
  input  wire logic [15:0] wr_data,
  // contents
  output var  logic [15:0] value
);

  localparam logic [15:0] RESET_VALUE = {2'h0, RESET_CODE, 2'h0, RESET_CODE} & IMPL_MASK;

  // masked store, reset value per field
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      value <= RESET_VALUE;
    else if (wr_en)
      value <= wr_data & IMPL_MASK;
  end

endmodule : select_pair_reg
`default_nettype wire

//--- pin_input_route.sv
// routes a selected remappable pin, or ground, to one peripheral input
// assumes pin levels are synchronous to clk
`timescale 1ns/1ns
`default_nettype none
module pin_input_route
  import pin_select_pkg::*;
#(
  parameter int unsigned PINS = PIN_COUNT
)(
  // clock and reset
  input  wire logic            clk,
  input  wire logic            sys_rst,
  // selection and pins
  input  wire logic [5:0]      choice,
  input  wire logic [PINS-1:0] pins,
  // routed level
  output var  logic            routed
);

  wire in_range = ({26'h0, choice} < PINS);
  wire grounded = (choice == SEL_GROUND);
  wire picked   = (in_range && !grounded) ? pins[choice] : 1'b0;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      routed <= 1'b0;
    else
      routed <= picked;
  end

endmodule : pin_input_route
`default_nettype wire

//--- pin_side_model.sv
// far-side model: levels on the remappable pins seen by the map
// assumes the bench asks for new levels right after a clock edge
`timescale 1ns/1ns
`default_nettype none
module pin_side_model #(
  parameter int unsigned PINS = 36
)(
  // clock
  input  wire logic            clk,
  // requested and driven levels
  input  wire logic [PINS-1:0] level_req,
  output var  logic [PINS-1:0] pin_level
);
  // ==========================================================
  // pins change just after an edge, like a synchronous port
  always_ff @(posedge clk)
  begin
    pin_level <= level_req;
  end
endmodule : pin_side_model
`default_nettype wire

//--- tb_top.sv
// testbench for the remappable pin select map, full and small variant
// assumes the design files and pin_side_model are compiled first
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import pin_select_pkg::*;
  // ==========================================================
  // signals
  logic        clk       = 1'b0;
  logic        sys_rst   = 1'b1;
  logic        hsel      = 1'b0;
  logic [31:0] haddr     = 32'h0;
  logic [1:0]  htrans    = 2'h0;
  logic        hwrite    = 1'b0;
  logic [2:0]  hsize     = 3'h2;
  logic [31:0] hwdata    = 32'h0;
  logic [35:0] pin_req   = 36'hf_ffff_ffff;
  logic        small_sel = 1'b0;
  logic [31:0] rd;
  logic [83:0] exp_f;
  logic [5:0]  c;
  logic [5:0]  codes [7] = '{6'h00, 6'h11, 6'h20, 6'h21, 6'h22, 6'h23, 6'h3f};
  int          err_count = 0;
  int          n_checks  = 0;
  wire  logic [31:0] hrdata;
  wire  logic [31:0] hrdata_s;
  wire  logic        hreadyout;
  wire  logic        hresp;
  wire  logic        hready;
  wire  logic [35:0] pins;
  wire  logic [6:0]  routed;
  wire  logic [83:0] func;
  wire  logic [83:0] func_s;
  wire  logic [13:0] owned;

  assign hready = hreadyout;
  always #25 clk = ~clk;

  // ==========================================================
  // instances
  pin_side_model #(.PINS(36)) pin_side (.clk(clk), .level_req(pin_req), .pin_level(pins));

  remappable_pin_select_map #(.PINS(36), .SMALL_PART(1'b0)) dut (
    .clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .remappable_pin(pins),
    .pwm_fault_input_4(routed[0]), .pwm_fault_input_5(routed[1]),
    .pwm_fault_input_6(routed[2]), .pwm_fault_input_7(routed[3]),
    .pwm_fault_input_8(routed[4]), .pwm_sync_input_a(routed[5]),
    .pwm_sync_input_b(routed[6]), .pin_function_choice(func), .pin_port_owned(owned));

  remappable_pin_select_map #(.PINS(36), .SMALL_PART(1'b1)) dut_small (
    .clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata_s),
    .hreadyout(), .hresp(), .remappable_pin(pins), .pwm_fault_input_4(),
    .pwm_fault_input_5(), .pwm_fault_input_6(), .pwm_fault_input_7(),
    .pwm_fault_input_8(), .pwm_sync_input_a(), .pwm_sync_input_b(),
    .pin_function_choice(func_s), .pin_port_owned());

  // ==========================================================
  // compare and bus tasks
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_out(input logic [83:0] got, input logic [83:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_out

  // waits for the slave as long as it takes; only the watchdog ends a hang
  task automatic wait_ready;
    @(posedge clk);
    while (hready !== 1'b1)
      @(posedge clk);
  endtask : wait_ready

  // one single transfer; an idle cycle follows a write
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= {26'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = small_sel ? hrdata_s : hrdata;
    if (wr)
      @(posedge clk);
  endtask : bus

  task automatic wr(input logic [5:0] a, input logic [31:0] wd);
    bus(1'b1, a, wd);
  endtask : wr

  task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk_reg(rd, exp);
    chk_reg({30'h0, hreadyout, hresp}, 32'h2);
  endtask : rd_chk

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish

  // ==========================================================
  // watchdog
  initial
  begin
    repeat (5000) @(posedge clk);
    err_count++;
    tally_and_finish();
  end

  // ==========================================================
  // tests
  initial
  begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 4; i++)
      rd_chk(ADDR_FAULT_5_4 + 6'(4*i), (i == 3) ? 32'h3f : 32'h3f3f);
    for (int i = 0; i < 7; i++)
      rd_chk(ADDR_OUT_BASE + 6'(4*i), 32'h0);
    chk_out(func, 84'h0);
    chk_out({70'h0, owned}, {70'h0, 14'h3fff});
    chk_out({77'h0, routed}, 84'h0);
    $display("test reset_values done");

    wr(ADDR_FAULT_5_4, 32'hffff_ffff);
    rd_chk(ADDR_FAULT_5_4, 32'h3f3f);
    wr(ADDR_SYNC2, 32'hffff_ffff);
    rd_chk(ADDR_SYNC2, 32'h3f);
    wr(6'h2c, 32'h3f3f);
    rd_chk(6'h2c, 32'h0);
    $display("test masking done");

    wr(ADDR_FAULT_5_4, 32'h0201);
    wr(ADDR_FAULT_7_6, 32'h0403);
    wr(ADDR_SYNC1_F8, 32'h0605);
    wr(ADDR_SYNC2, 32'h0007);
    rd_chk(ADDR_SYNC1_F8, 32'h0605);
    for (int k = 0; k < 7; k++)
    begin
      pin_req <= 36'h1 << (k + 1);
      repeat (3) @(posedge clk);
      chk_out({77'h0, routed}, 84'h1 << k);
    end
    $display("test field_placement done");

    foreach (codes[j])
    begin
      c = codes[j];
      for (int r = 0; r < 4; r++)
        wr(ADDR_FAULT_5_4 + 6'(4*r), {18'h0, c, 2'h0, c});
      pin_req <= (c == 6'h3f) ? 36'hf_ffff_ffff : 36'h1 << c;
      repeat (3) @(posedge clk);
      chk_out({77'h0, routed}, (c == 6'h3f) ? 84'h0 : 84'h7f);
      pin_req <= ~(36'h1 << c);
      repeat (3) @(posedge clk);
      chk_out({77'h0, routed}, 84'h0);
    end
    $display("test input_codes done");

    for (int i = 0; i < 7; i++)
      wr(ADDR_OUT_BASE + 6'(4*i), {18'h0, 6'(2*i+1), 2'h0, 6'(2*i)});
    for (int n = 0; n < 14; n++)
      exp_f[6*n +: 6] = 6'(n);
    repeat (2) @(posedge clk);
    chk_out(func, exp_f);
    chk_out({70'h0, owned}, {70'h0, 14'h0001});
    rd_chk(ADDR_OUT_BASE + 6'h18, 32'h0d0c);
    small_sel = 1'b1;
    rd_chk(ADDR_OUT_BASE + 6'h18, 32'h0);
    rd_chk(ADDR_OUT_BASE + 6'h0c, 32'h0706);
    small_sel = 1'b0;
    chk_out(func_s, {36'h0, exp_f[47:0]});
    $display("test output_select done");
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
